// >>> rtl/rael_latch.sv
// Purpose: receive alarm/event latch registers behind an APB slave
// Assumes: condition levels and event strobes are synchronous to pclk
// Notes: all flags are write-one-to-clear; set wins over clear
//
// Contract
// - Every bit of the line alarm latch latches and can raise the interrupt.
// - Clear flags bits 7..4 set on falling edge of remote, AIS, LOS, LOF conditions.
// - LOS detect flag sets on rising edge of signal loss (192 zeros).
// - AIS detect flag bit 2 sets on rising edge of all-ones alarm.
// - LOF detect bit 0 and remote alarm detect bit 3 set on rising edges.
// - T1 framing latch bits 7 and 5..0 latch, bit 6 never sets; none raise the interrupt.
// - T1 pulse density violation sets bit 7.
// - T1 alignment change sets bit 5.
// - T1 eight-zero and sixteen-zero run flags set on their strobes.
// - T1 severe framing error flag sets on two of six framing errors.
// - T1 B8ZS codeword flag sets regardless of line coding selection.
// - T1 framing bit error flag bit 0 sets per errored framing bit.
// - E1 framing latch bits 6..0 latch, bit 7 never sets; only bits 0..3 raise the interrupt.
// - E1 CRC resync criteria flag sets on its strobe.
// - E1 CAS resync criteria flag sets on its strobe.
// - E1 FAS resync criteria flag sets on its strobe.
// - E1 signaling all-ones flag sets on its strobe, also in CCS mode.
// - E1 signaling all-zeros flag sets on its strobe.
// - E1 CRC-4 multiframe flag sets on each multiframe mark.
// - E1 align frame flag sets on each align frame mark.
// - T1 clock loss, spare, loop-down, loop-up clear flags set on falling edges.
// - Clock loss detect flag sets on rising edge of clock loss.
`timescale 1ns/1ps
`include "rael_defs.svh"
module rael_latch (
	input wire logic pclk, // APB clock, 10 MHz
	input wire logic presetn, // Async reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [11:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error on unmapped address
	input wire rael_pkg::rael_line_cond_t line_cond, // Line alarm levels
	input wire rael_pkg::rael_loop_cond_t loop_cond, // Clock and loop code levels
	input wire rael_pkg::rael_t1_evt_t t1_evt, // T1 event strobes
	input wire rael_pkg::rael_e1_evt_t e1_evt, // E1 event strobes
	output logic irq, // Interrupt request, active high
	output logic e1_mode // Current mode, 1 = E1
);
	logic [7:0] line_latch;
	logic [7:0] t1_latch;
	logic [7:0] e1_latch;
	logic [7:0] loop_latch;
	logic [7:0] irq_mask_line;
	logic [7:0] irq_mask_fr;
	logic [7:0] irq_mask_loop;
	logic [3:0] line_q;
	logic [3:0] loop_q;
	rael_pkg::rael_apb_state_t state;

	wire [9:0] reg_idx = paddr[11:2];
	wire sel_line = (reg_idx == `RAEL_IDX_LINE);
	wire sel_fr = (reg_idx == `RAEL_IDX_FRAMING);
	wire sel_loop = (reg_idx == `RAEL_IDX_CLOCK);
	wire sel_ctrl = (reg_idx == `RAEL_IDX_CTRL);
	wire sel_cond = (reg_idx == `RAEL_IDX_COND);
	wire sel_mask_line = (reg_idx == `RAEL_IDX_MASK_LINE);
	wire sel_mask_fr = (reg_idx == `RAEL_IDX_MASK_FR);
	wire sel_mask_loop = (reg_idx == `RAEL_IDX_MASK_LOOP);
	wire mapped = sel_line | sel_fr | sel_loop | sel_ctrl | sel_cond | sel_mask_line | sel_mask_fr | sel_mask_loop;
	// Access completes with zero wait states in the access phase
	wire acc = psel & penable & (state == rael_pkg::RAEL_ACCESS);
	wire wr = acc & pwrite & mapped;
	wire rd = acc & ~pwrite;
	wire [7:0] w1c = pwdata[7:0];

	wire [3:0] line_now = line_cond;
	wire [3:0] loop_now = loop_cond;
	wire [3:0] line_rise = line_now & ~line_q;
	wire [3:0] line_fall = ~line_now & line_q;
	wire [3:0] loop_rise = loop_now & ~loop_q;
	wire [3:0] loop_fall = ~loop_now & loop_q;
	wire [7:0] line_set = {line_fall, line_rise};
	wire [7:0] loop_set = {loop_fall, loop_rise};
	wire [7:0] t1_set = {t1_evt.pulse_density_violation, 1'b0, t1_evt.alignment_changed, t1_evt.eight_zero_run,
		t1_evt.sixteen_zero_run, t1_evt.severe_framing_error, t1_evt.b8zs_codeword, t1_evt.framing_bit_error}
		& {8{~e1_mode}} & `RAEL_T1_UNUSED_MASK;
	wire [7:0] e1_set = {1'b0, e1_evt} & {8{e1_mode}} & `RAEL_E1_UNUSED_MASK;
	wire [7:0] fr_view = e1_mode ? e1_latch : t1_latch;
	wire [7:0] fr_irq_ok = e1_mode ? `RAEL_E1_IRQ_MASK : `RAEL_T1_IRQ_MASK;
	wire line_irq_hit = |(line_latch & irq_mask_line);
	wire fr_irq_hit = |(fr_view & fr_irq_ok & irq_mask_fr);
	wire loop_irq_hit = |(loop_latch & irq_mask_loop);
	wire next_irq = line_irq_hit | fr_irq_hit | loop_irq_hit;

	wire [7:0] rd_byte = sel_line ? line_latch :
		sel_fr ? fr_view :
		sel_loop ? loop_latch :
		sel_ctrl ? {7'h00, e1_mode} :
		sel_cond ? {loop_q, line_q} :
		sel_mask_line ? irq_mask_line :
		sel_mask_fr ? irq_mask_fr :
		sel_mask_loop ? irq_mask_loop : `RAEL_RST_BYTE;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= rael_pkg::RAEL_IDLE;
		end else begin
			case (state)
				rael_pkg::RAEL_IDLE: state <= (psel & ~penable) ? rael_pkg::RAEL_ACCESS : rael_pkg::RAEL_IDLE;
				rael_pkg::RAEL_ACCESS: state <= (psel & ~penable) ? rael_pkg::RAEL_ACCESS :
					(acc ? rael_pkg::RAEL_IDLE : rael_pkg::RAEL_ACCESS);
				default: state <= rael_pkg::RAEL_IDLE;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			pready <= psel & ~penable;
			pslverr <= psel & ~penable & ~mapped;
			prdata <= (psel & ~penable & ~pwrite) ? {24'h000000, rd_byte} : 32'h00000000;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			line_q <= 4'h0;
			loop_q <= 4'h0;
			irq <= 1'b0;
		end else begin
			line_q <= line_now;
			loop_q <= loop_now;
			irq <= next_irq;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			e1_mode <= 1'b0;
			irq_mask_line <= `RAEL_RST_BYTE;
			irq_mask_fr <= `RAEL_RST_BYTE;
			irq_mask_loop <= `RAEL_RST_BYTE;
		end else begin
			if (wr & sel_ctrl)
				e1_mode <= pwdata[`RAEL_CTRL_E1_BIT];
			if (wr & sel_mask_line)
				irq_mask_line <= pwdata[7:0];
			if (wr & sel_mask_fr)
				irq_mask_fr <= pwdata[7:0];
			if (wr & sel_mask_loop)
				irq_mask_loop <= pwdata[7:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			line_latch <= `RAEL_RST_BYTE;
			t1_latch <= `RAEL_RST_BYTE;
			e1_latch <= `RAEL_RST_BYTE;
			loop_latch <= `RAEL_RST_BYTE;
		end else begin
			line_latch <= (line_latch & ~(w1c & {8{wr & sel_line}})) | line_set;
			t1_latch <= (t1_latch & ~(w1c & {8{wr & sel_fr & ~e1_mode}})) | t1_set;
			e1_latch <= (e1_latch & ~(w1c & {8{wr & sel_fr & e1_mode}})) | e1_set;
			loop_latch <= (loop_latch & ~(w1c & {8{wr & sel_loop}})) | loop_set;
		end
	end

	// Assertions
	rising_lof_a: assert property (@(posedge pclk) disable iff (!presetn)
		(line_cond.frame_loss_cond && !$past(line_cond.frame_loss_cond)) |=> line_latch[0])
		else $error("frame loss rise not latched");
	rising_los_a: assert property (@(posedge pclk) disable iff (!presetn)
		(line_cond.signal_loss_cond && !$past(line_cond.signal_loss_cond)) |=> line_latch[1])
		else $error("signal loss rise not latched");
	falling_line_a: assert property (@(posedge pclk) disable iff (!presetn)
		(!line_cond.remote_alarm_cond && $past(line_cond.remote_alarm_cond)) |=> line_latch[7])
		else $error("remote alarm clear not latched");
	ais_detect_a: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(line_cond.all_ones_alarm_cond) |=> line_latch[2])
		else $error("all ones alarm not latched");
	clock_loss_a: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(loop_cond.rx_clock_loss_cond) |=> loop_latch[3])
		else $error("clock loss not latched");
	loop_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
		$fell(loop_cond.loop_up_cond) |=> loop_latch[4])
		else $error("loop up clear not latched");
	t1_no_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
		(!e1_mode && line_latch == 8'h00 && loop_latch == 8'h00) |=> !irq)
		else $error("T1 framing latch raised interrupt");
	e1_high_no_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
		(e1_mode && line_latch == 8'h00 && loop_latch == 8'h00 && e1_latch[3:0] == 4'h0) |=> !irq)
		else $error("E1 upper bits raised interrupt");
	line_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
		(|(line_latch & irq_mask_line)) |=> irq)
		else $error("line latch did not interrupt");
	hold_set_a: assert property (@(posedge pclk) disable iff (!presetn)
		(line_latch[0] && !(wr && sel_line && pwdata[0])) |=> line_latch[0])
		else $error("flag lost without clear");
	set_wins_a: assert property (@(posedge pclk) disable iff (!presetn)
		(wr && sel_fr && !e1_mode && t1_evt.framing_bit_error) |=> t1_latch[0])
		else $error("event lost under clear");
	t1_evt_a: assert property (@(posedge pclk) disable iff (!presetn)
		(!e1_mode && t1_evt.pulse_density_violation) |=> t1_latch[7])
		else $error("T1 event not latched");
	e1_evt_a: assert property (@(posedge pclk) disable iff (!presetn)
		(e1_mode && e1_evt.crc4_multiframe_mark) |=> e1_latch[1])
		else $error("E1 multiframe not latched");
	apb_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
		(psel && !penable) |=> pready)
		else $error("ready not given");

	// Remaining line edges
	remote_rise_a: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(line_cond.remote_alarm_cond) |=> line_latch[3])
		else $error("remote alarm rise not latched");
	ais_fall_a: assert property (@(posedge pclk) disable iff (!presetn)
		$fell(line_cond.all_ones_alarm_cond) |=> line_latch[6])
		else $error("all ones clear not latched");
	los_fall_a: assert property (@(posedge pclk) disable iff (!presetn)
		$fell(line_cond.signal_loss_cond) |=> line_latch[5])
		else $error("signal loss clear not latched");
	lof_fall_a: assert property (@(posedge pclk) disable iff (!presetn)
		$fell(line_cond.frame_loss_cond) |=> line_latch[4])
		else $error("frame loss clear not latched");

	// Clock and loop code edges, same layout in both modes
	clock_fall_a: assert property (@(posedge pclk) disable iff (!presetn)
		$fell(loop_cond.rx_clock_loss_cond) |=> loop_latch[7])
		else $error("clock loss clear not latched");
	spare_fall_a: assert property (@(posedge pclk) disable iff (!presetn)
		$fell(loop_cond.spare_code_cond) |=> loop_latch[6])
		else $error("spare code clear not latched");
	down_fall_a: assert property (@(posedge pclk) disable iff (!presetn)
		$fell(loop_cond.loop_down_cond) |=> loop_latch[5])
		else $error("loop down clear not latched");
	spare_rise_a: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(loop_cond.spare_code_cond) |=> loop_latch[2])
		else $error("spare code detect not latched");
	down_rise_a: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(loop_cond.loop_down_cond) |=> loop_latch[1])
		else $error("loop down detect not latched");
	up_rise_a: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(loop_cond.loop_up_cond) |=> loop_latch[0])
		else $error("loop up detect not latched");

	// T1 event strobes, one flag each
	align_change_a: assert property (@(posedge pclk) disable iff (!presetn)
		(!e1_mode && t1_evt.alignment_changed) |=> t1_latch[5])
		else $error("alignment change not latched");
	eight_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
		(!e1_mode && t1_evt.eight_zero_run) |=> t1_latch[4])
		else $error("eight zero run not latched");
	sixteen_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
		(!e1_mode && t1_evt.sixteen_zero_run) |=> t1_latch[3])
		else $error("sixteen zero run not latched");
	severe_frame_a: assert property (@(posedge pclk) disable iff (!presetn)
		(!e1_mode && t1_evt.severe_framing_error) |=> t1_latch[2])
		else $error("severe framing error not latched");
	b8zs_word_a: assert property (@(posedge pclk) disable iff (!presetn)
		(!e1_mode && t1_evt.b8zs_codeword) |=> t1_latch[1])
		else $error("B8ZS codeword not latched");
	frame_bit_a: assert property (@(posedge pclk) disable iff (!presetn)
		(!e1_mode && t1_evt.framing_bit_error) |=> t1_latch[0])
		else $error("framing bit error not latched");

	// E1 event strobes, one flag each
	crc_resync_a: assert property (@(posedge pclk) disable iff (!presetn)
		(e1_mode && e1_evt.crc_resync_criteria) |=> e1_latch[6])
		else $error("CRC resync not latched");
	cas_resync_a: assert property (@(posedge pclk) disable iff (!presetn)
		(e1_mode && e1_evt.cas_resync_criteria) |=> e1_latch[5])
		else $error("CAS resync not latched");
	fas_resync_a: assert property (@(posedge pclk) disable iff (!presetn)
		(e1_mode && e1_evt.fas_resync_criteria) |=> e1_latch[4])
		else $error("FAS resync not latched");
	sig_ones_a: assert property (@(posedge pclk) disable iff (!presetn)
		(e1_mode && e1_evt.signaling_all_ones) |=> e1_latch[3])
		else $error("signaling all ones not latched");
	sig_zeros_a: assert property (@(posedge pclk) disable iff (!presetn)
		(e1_mode && e1_evt.signaling_all_zeros) |=> e1_latch[2])
		else $error("signaling all zeros not latched");
	align_frame_a: assert property (@(posedge pclk) disable iff (!presetn)
		(e1_mode && e1_evt.align_frame_mark) |=> e1_latch[0])
		else $error("align frame not latched");

	// Strobes of the idle layout must not leak into it
	t1_gated_a: assert property (@(posedge pclk) disable iff (!presetn)
		(e1_mode && t1_latch == 8'h00) |=> t1_latch == 8'h00)
		else $error("T1 layout set in E1 mode");
	e1_gated_a: assert property (@(posedge pclk) disable iff (!presetn)
		(!e1_mode && e1_latch == 8'h00) |=> e1_latch == 8'h00)
		else $error("E1 layout set in T1 mode");
	t1_spare_a: assert property (@(posedge pclk) disable iff (!presetn)
		!t1_latch[6])
		else $error("T1 unused bit set");
	e1_spare_a: assert property (@(posedge pclk) disable iff (!presetn)
		!e1_latch[7])
		else $error("E1 unused bit set");

	// Interrupt paths
	e1_low_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
		(e1_mode && |(e1_latch[3:0] & irq_mask_fr[3:0])) |=> irq)
		else $error("E1 low bits did not interrupt");
	loop_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
		(|(loop_latch & irq_mask_loop)) |=> irq)
		else $error("loop latch did not interrupt");

	// Write-one clear when no event lands in the same cycle
	line_w1c_a: assert property (@(posedge pclk) disable iff (!presetn)
		(wr && sel_line && line_set == 8'h00) |=> line_latch == ($past(line_latch) & ~$past(w1c)))
		else $error("line latch clear wrong");
	t1_w1c_a: assert property (@(posedge pclk) disable iff (!presetn)
		(wr && sel_fr && !e1_mode && t1_set == 8'h00) |=> t1_latch == ($past(t1_latch) & ~$past(w1c)))
		else $error("T1 latch clear wrong");
	e1_w1c_a: assert property (@(posedge pclk) disable iff (!presetn)
		(wr && sel_fr && e1_mode && e1_set == 8'h00) |=> e1_latch == ($past(e1_latch) & ~$past(w1c)))
		else $error("E1 latch clear wrong");
	loop_w1c_a: assert property (@(posedge pclk) disable iff (!presetn)
		(wr && sel_loop && loop_set == 8'h00) |=> loop_latch == ($past(loop_latch) & ~$past(w1c)))
		else $error("loop latch clear wrong");

	// per bit: an event always lands, a flag drops only on its own clear
	for (genvar b = 0; b < 8; b++) begin : g_flag
		set_line_a: assert property (@(posedge pclk) disable iff (!presetn)
			line_set[b] |=> line_latch[b])
			else $error("line event lost");
		set_loop_a: assert property (@(posedge pclk) disable iff (!presetn)
			loop_set[b] |=> loop_latch[b])
			else $error("loop event lost");
		set_t1_a: assert property (@(posedge pclk) disable iff (!presetn)
			t1_set[b] |=> t1_latch[b])
			else $error("T1 event lost");
		set_e1_a: assert property (@(posedge pclk) disable iff (!presetn)
			e1_set[b] |=> e1_latch[b])
			else $error("E1 event lost");
		hold_line_a: assert property (@(posedge pclk) disable iff (!presetn)
			(line_latch[b] && !(wr && sel_line && w1c[b])) |=> line_latch[b])
			else $error("line flag dropped");
		hold_loop_a: assert property (@(posedge pclk) disable iff (!presetn)
			(loop_latch[b] && !(wr && sel_loop && w1c[b])) |=> loop_latch[b])
			else $error("loop flag dropped");
		hold_t1_a: assert property (@(posedge pclk) disable iff (!presetn)
			(t1_latch[b] && !(wr && sel_fr && !e1_mode && w1c[b])) |=> t1_latch[b])
			else $error("T1 flag dropped");
		hold_e1_a: assert property (@(posedge pclk) disable iff (!presetn)
			(e1_latch[b] && !(wr && sel_fr && e1_mode && w1c[b])) |=> e1_latch[b])
			else $error("E1 flag dropped");
	end

	// Bus side
	ready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
		pready |=> !pready)
		else $error("ready held too long");
	unmapped_err_a: assert property (@(posedge pclk) disable iff (!presetn)
		(psel && !penable && !mapped) |=> pslverr)
		else $error("unmapped access not flagged");
	read_upper_a: assert property (@(posedge pclk) disable iff (!presetn)
		rd |-> prdata[31:8] == 24'h000000)
		else $error("read upper bits not zero");
	idle_data_a: assert property (@(posedge pclk) disable iff (!presetn)
		!(psel && !penable && !pwrite) |=> prdata == 32'h00000000)
		else $error("read data left standing");
	mode_write_a: assert property (@(posedge pclk) disable iff (!presetn)
		(wr && sel_ctrl) |=> e1_mode == $past(pwdata[`RAEL_CTRL_E1_BIT]))
		else $error("mode write lost");
	mask_write_a: assert property (@(posedge pclk) disable iff (!presetn)
		(wr && sel_mask_line) |=> irq_mask_line == $past(w1c))
		else $error("line mask write lost");
	unmapped_wr_a: assert property (@(posedge pclk) disable iff (!presetn)
		(acc && pwrite && !mapped) |=> e1_mode == $past(e1_mode))
		else $error("unmapped write took effect");
	cond_read_a: assert property (@(posedge pclk) disable iff (!presetn)
		(psel && !penable && !pwrite && sel_cond) |=> prdata[7:0] == $past({loop_q, line_q}))
		else $error("condition read wrong");
endmodule

// >>> rtl/rael_defs.svh
// Purpose: offsets, field positions and reset values for the receive alarm/event latch
// Assumes: APB byte addresses are four times the register index
// Notes: definitions only
`ifndef RAEL_DEFS_SVH
`define RAEL_DEFS_SVH
`define RAEL_IDX_LINE 10'h090
`define RAEL_IDX_FRAMING 10'h091
`define RAEL_IDX_CLOCK 10'h092
`define RAEL_IDX_CTRL 10'h0A0
`define RAEL_IDX_COND 10'h0A1
`define RAEL_IDX_MASK_LINE 10'h0A2
`define RAEL_IDX_MASK_FR 10'h0A3
`define RAEL_IDX_MASK_LOOP 10'h0A4
`define RAEL_RST_BYTE 8'h00
`define RAEL_E1_IRQ_MASK 8'h0F
`define RAEL_T1_IRQ_MASK 8'h00
`define RAEL_E1_UNUSED_MASK 8'h7F
`define RAEL_T1_UNUSED_MASK 8'hBF
`define RAEL_CTRL_E1_BIT 0
`endif

// >>> rtl/rael_pkg.sv
// Purpose: shared types for the receive alarm/event latch
// Assumes: nothing beyond the defs header
// Notes: condition and event groups travel as packed structs
package rael_pkg;
	typedef struct packed {
		logic remote_alarm_cond;
		logic all_ones_alarm_cond;
		logic signal_loss_cond;
		logic frame_loss_cond;
	} rael_line_cond_t;
	typedef struct packed {
		logic rx_clock_loss_cond;
		logic spare_code_cond;
		logic loop_down_cond;
		logic loop_up_cond;
	} rael_loop_cond_t;
	// One-cycle event strobes from the framer detectors, in register bit order
	typedef struct packed {
		logic pulse_density_violation;
		logic alignment_changed;
		logic eight_zero_run;
		logic sixteen_zero_run;
		logic severe_framing_error;
		logic b8zs_codeword;
		logic framing_bit_error;
	} rael_t1_evt_t;
	typedef struct packed {
		logic crc_resync_criteria;
		logic cas_resync_criteria;
		logic fas_resync_criteria;
		logic signaling_all_ones;
		logic signaling_all_zeros;
		logic crc4_multiframe_mark;
		logic align_frame_mark;
	} rael_e1_evt_t;
	typedef enum logic [1:0] {RAEL_IDLE, RAEL_ACCESS} rael_apb_state_t;
endpackage

// >>> test/rael_framer_model.sv
// Purpose: stand-in for the receive framer condition detectors
// Assumes: levels and strobes change just after pclk rises
// Notes: strobes last exactly one cycle, levels hold until changed
`timescale 1ns/1ps
module rael_framer_model (
	input wire logic pclk, // Bench clock
	output rael_pkg::rael_line_cond_t line_cond, // Line alarm levels
	output rael_pkg::rael_loop_cond_t loop_cond, // Clock and loop code levels
	output rael_pkg::rael_t1_evt_t t1_evt, // T1 event strobes
	output rael_pkg::rael_e1_evt_t e1_evt // E1 event strobes
);
	initial begin
		line_cond = '0;
		loop_cond = '0;
		t1_evt = '0;
		e1_evt = '0;
	end
	task automatic levels(input logic [3:0] ln, input logic [3:0] lp);
		@(posedge pclk);
		line_cond <= ln;
		loop_cond <= lp;
	endtask
	task automatic strobe(input logic [6:0] t1, input logic [6:0] e1);
		@(posedge pclk);
		t1_evt <= t1;
		e1_evt <= e1;
		@(posedge pclk);
		t1_evt <= '0;
		e1_evt <= '0;
	endtask
endmodule

// >>> test/rx_alarm_event_latch_test.sv
// Purpose: self-checking bench for the receive alarm/event latch
// Assumes: zero-wait APB slave, byte address four times the index
// Notes: opposite-mode strobes run alongside to catch wrong gating
`timescale 1ns/1ps
module rx_alarm_event_latch_test;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready, pslverr, irq, e1_mode;
	rael_pkg::rael_line_cond_t line_cond;
	rael_pkg::rael_loop_cond_t loop_cond;
	rael_pkg::rael_t1_evt_t t1_evt;
	rael_pkg::rael_e1_evt_t e1_evt;
	int err_total = 0;
	int num_checks = 0;
	always #50 pclk = ~pclk;
	rael_latch i_rael_latch (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .line_cond(line_cond), .loop_cond(loop_cond), .t1_evt(t1_evt),
		.e1_evt(e1_evt), .irq(irq), .e1_mode(e1_mode));
	rael_framer_model i_rael_framer_model (.pclk(pclk), .line_cond(line_cond),
		.loop_cond(loop_cond), .t1_evt(t1_evt), .e1_evt(e1_evt));
	task automatic print_verdict;
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input logic [7:0] g, input logic [7:0] x);
		num_checks++;
		if (g !== x) begin
			err_total++;
			$display("BAD %0t got %h expected %h", $time, g, x);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
		output logic [7:0] r, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata[7:0];
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [7:0] x);
		logic [7:0] r;
		logic e;
		apb(1'b0, a, 8'h00, r, e);
		chk(r, x);
		chk({7'h00, e}, 8'h00);
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		logic [7:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask
	task automatic wt;
		repeat (3) @(posedge pclk);
	endtask
	task automatic t_reset;
		rd(12'h240, 8'h00);
		rd(12'h244, 8'h00);
		rd(12'h248, 8'h00);
		chk({7'h00, e1_mode}, 8'h00);
		rd(12'h280, 8'h00);
		rd(12'h284, 8'h00);
		rd(12'h288, 8'h00);
		rd(12'h28C, 8'h00);
		rd(12'h290, 8'h00);
		chk({7'h00, irq}, 8'h00);
	endtask
	task automatic t_line;
		i_rael_framer_model.levels(4'hF, 4'h0);
		wt();
		rd(12'h240, 8'h0F);
		rd(12'h284, 8'h0F);
		wr(12'h240, 8'h0A);
		rd(12'h240, 8'h05);
		i_rael_framer_model.levels(4'h0, 4'h0);
		wt();
		rd(12'h240, 8'hF5);
		wr(12'h240, 8'hFF);
		rd(12'h240, 8'h00);
	endtask
	task automatic t_loop;
		i_rael_framer_model.levels(4'h0, 4'hF);
		wt();
		rd(12'h248, 8'h0F);
		rd(12'h284, 8'hF0);
		i_rael_framer_model.levels(4'h0, 4'h0);
		wt();
		rd(12'h248, 8'hFF);
		wr(12'h248, 8'hFF);
		rd(12'h248, 8'h00);
	endtask
	task automatic t_irq;
		wr(12'h288, 8'hFF);
		rd(12'h288, 8'hFF);
		i_rael_framer_model.levels(4'h1, 4'h0);
		wt();
		chk({7'h00, irq}, 8'h01);
		wr(12'h240, 8'hFF);
		wt();
		chk({7'h00, irq}, 8'h00);
		wr(12'h288, 8'h00);
		i_rael_framer_model.levels(4'h0, 4'h0);
		wt();
		chk({7'h00, irq}, 8'h00);
		wr(12'h240, 8'hFF);
	endtask
	task automatic t_t1;
		wr(12'h28C, 8'hFF);
		for (int i = 0; i < 7; i++) begin
			i_rael_framer_model.strobe(7'h01 << i, 7'h7F);
			wt();
			rd(12'h244, (i == 6) ? 8'h80 : (8'h01 << i));
			chk({7'h00, irq}, 8'h00);
			wr(12'h244, 8'hFF);
		end
	endtask
	task automatic t_e1;
		wr(12'h280, 8'h01);
		wt();
		chk({7'h00, e1_mode}, 8'h01);
		rd(12'h280, 8'h01);
		rd(12'h244, 8'h00);
		for (int i = 0; i < 7; i++) begin
			i_rael_framer_model.strobe(7'h7F, 7'h01 << i);
			wt();
			rd(12'h244, 8'h01 << i);
			chk({7'h00, irq}, {7'h00, i < 4});
			wr(12'h244, 8'hFF);
			wt();
		end
		wr(12'h280, 8'h00);
		rd(12'h244, 8'h00);
	endtask
	task automatic t_unmapped;
		logic [7:0] r;
		logic e;
		apb(1'b0, 12'hFFC, 8'h00, r, e);
		chk({e, r[6:0]}, 8'h80);
		apb(1'b1, 12'hFFC, 8'hFF, r, e);
		chk({7'h00, e}, 8'h01);
	endtask
	// Reset in mid-run with a condition standing: it must be seen again
	task automatic t_midreset;
		wr(12'h280, 8'h01);
		wr(12'h288, 8'hFF);
		i_rael_framer_model.levels(4'h1, 4'h0);
		wt();
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		chk({6'h00, irq, e1_mode}, 8'h00);
		rd(12'h288, 8'h00);
		rd(12'h240, 8'h01);
		i_rael_framer_model.levels(4'h0, 4'h0);
		wt();
		rd(12'h240, 8'h11);
		wr(12'h240, 8'hFF);
	endtask
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_line();
		t_loop();
		t_irq();
		t_t1();
		t_e1();
		t_unmapped();
		t_midreset();
		print_verdict();
	end
	initial begin
		#500000;
		err_total++;
		print_verdict();
	end
endmodule
